/* File: fp_mulsin_dec.sv */
/*
 * Coprocessor decoder and executor for the single-precision multiply and
 * the sine operation, with operand-field decoding of the divide.
 * Assumes an AHB-Lite master; the host fetches any memory operand itself
 * and places it in the source register before issuing the command word.
 */
// Overview of operation
// - Coprocessor ID field selects executor; this unit answers its own ID, default 1.
// - Operand select bit: 0 register to register, 1 memory operand to register.
// - Register-to-register: source specifier names the source data register.
// - Memory operand: source specifier gives long, single, extended, packed, word, double, byte; extended, packed and double are refused here.
// - Address mode decoded per mode field, mode 111 subdivided by register field.
// - Destination field names the data register receiving the result.
// - Multiply source by destination, product rounded to single precision.
// - Mantissas beyond 24 bits are truncated before the multiply.
// - Multiply result exponent is kept beyond single-precision range.
// - Zero times infinity gives NaN and operand error; signed zero, signed infinity.
// - Quotient byte unchanged; unordered-branch and divide-by-zero flags cleared.
// - Sine clears the overflow flag.
// - Input inexact only for packed input; cleared for every other format.
// - Accrued byte gathers the exception byte after each operation.
// - Sine converts source, computes sine, stores to destination register.
// - Sine reduces argument into plus/minus two pi; result within plus/minus one.
// - Sine of signed zero is same zero; infinity gives NaN and operand error.
`timescale 1ns/10ps
module fp_mulsin_dec #(
	parameter logic [2:0] OWN_ID = fmd_pkg::FPU_ID
) (
	// Clock, reset and enable
	input  wire logic        clk,
	input  wire logic        rst_n,
	input  wire logic        ce,
	// AHB-Lite slave
	input  wire logic        hsel,
	input  wire logic [31:0] haddr,
	input  wire logic [1:0]  htrans,
	input  wire logic        hwrite,
	input  wire logic [2:0]  hsize,
	input  wire logic        hready,
	input  wire logic [31:0] hwdata,
	output logic             hreadyout,
	output logic             hresp,
	output logic [31:0]      hrdata
);
	// ************************************************
	// Helper functions
	// ************************************************
	// Position of the highest set bit
	function automatic logic [5:0] lead1(input logic [43:0] v);
		lead1 = 6'h00;
		for (int i = 0; i < 44; i++) begin
			if (v[i]) lead1 = 6'(i);
		end
	endfunction : lead1

	// Normalise a magnitude, excess low bits truncated
	function automatic fmd_pkg::fp_val_t mkVal(input logic s, input logic [43:0] m,
		input logic signed [11:0] scale);
		logic [5:0]  p;
		logic [43:0] sh;
		p = lead1(m);
		sh = (p >= 6'h17) ? (m >> (p - 6'h17)) : (m << (6'h17 - p));
		mkVal.sign = s;
		mkVal.cls  = (m == 44'h0) ? fmd_pkg::CL_ZERO : fmd_pkg::CL_NUM;
		mkVal.exp  = $signed({6'h00, p}) - scale;
		mkVal.mant = sh[23:0];
	endfunction : mkVal

	// Single-precision word to internal form, denormals flushed
	function automatic fmd_pkg::fp_val_t fromIeee(input logic [31:0] w);
		fromIeee.sign = w[31];
		fromIeee.exp  = $signed({4'h0, w[30:23]}) - fmd_pkg::SGL_BIAS;
		fromIeee.mant = {1'b1, w[22:0]};
		if (w[30:23] == 8'h00) fromIeee.cls = fmd_pkg::CL_ZERO;
		else if (w[30:23] != 8'hff) fromIeee.cls = fmd_pkg::CL_NUM;
		else if (w[22:0] == 23'h0) fromIeee.cls = fmd_pkg::CL_INF;
		else fromIeee.cls = fmd_pkg::CL_NAN;
	endfunction : fromIeee

	// Internal form to single-precision view, saturating
	function automatic logic [31:0] toIeee(input fmd_pkg::fp_val_t v);
		logic signed [11:0] e;
		e = v.exp + fmd_pkg::SGL_BIAS;
		if (v.cls == fmd_pkg::CL_NAN) toIeee = {v.sign, 8'hff, 23'h400000};
		else if (v.cls == fmd_pkg::CL_INF) toIeee = {v.sign, 8'hff, 23'h0};
		else if (v.cls == fmd_pkg::CL_ZERO || e < 12'sh001) toIeee = {v.sign, 31'h0};
		else if (e > 12'sh0fe) toIeee = {v.sign, 8'hff, 23'h0};
		else toIeee = {v.sign, e[7:0], v.mant[22:0]};
	endfunction : toIeee

	// Addressing mode of an effective-address field
	function automatic fmd_pkg::ea_kind_t eaKindOf(input logic [2:0] md, input logic [2:0] rg);
		case (md)
			3'h0: eaKindOf = fmd_pkg::EA_DREG;
			3'h1: eaKindOf = fmd_pkg::EA_AREG;
			3'h2: eaKindOf = fmd_pkg::EA_IND;
			3'h3: eaKindOf = fmd_pkg::EA_POSTINC;
			3'h4: eaKindOf = fmd_pkg::EA_PREDEC;
			3'h5: eaKindOf = fmd_pkg::EA_DISP;
			3'h6: eaKindOf = fmd_pkg::EA_INDEX;
			default: begin
				case (rg)
					3'h0:       eaKindOf = fmd_pkg::EA_ABSW;
					3'h1:       eaKindOf = fmd_pkg::EA_ABSL;
					3'h4:       eaKindOf = fmd_pkg::EA_IMM;
					3'h2, 3'h3: eaKindOf = fmd_pkg::EA_PCREL;
					default:    eaKindOf = fmd_pkg::EA_BAD;
				endcase
			end
		endcase
	endfunction : eaKindOf

	// ************************************************
	// State
	// ************************************************
	fmd_pkg::state_t    state;
	fmd_pkg::fp_val_t   fpr [8];
	fmd_pkg::fp_val_t   srcLat, dstLat, resVal;
	fmd_pkg::cmd_t      lastCmd;
	fmd_pkg::ea_kind_t  eaKindL;
	logic [31:0]        srcData;
	logic [7:0]         qByte, exc, acc, newExc, accSet;
	logic signed [11:0] lastExp;
	logic               done, idMiss, eaBadL, fmtBadL, noExec, opIsSin, flip;
	logic [2:0]         dstIdx;
	logic [43:0]        rAcc;
	logic [4:0]         kCnt;
	logic [3:0]         it;
	logic signed [23:0] cx, cy, cz;
	logic               rdPend, wrPend;
	logic [7:0]         rdAddr, wrAddr;
	logic [31:0]        rdMux;

	// ************************************************
	// Bus decode
	// ************************************************
	wire addrPhase = hsel & htrans[1] & hready;
	wire fprWr     = wrAddr[7:5] == fmd_pkg::FPR_OFS[7:5] && wrAddr[1:0] == 2'b00;
	wire fprRd     = rdAddr[7:5] == fmd_pkg::FPR_OFS[7:5] && rdAddr[1:0] == 2'b00;
	wire wrCmd     = wrPend && wrAddr == fmd_pkg::CMD_OFS;
	wire wrSrc     = wrPend && wrAddr == fmd_pkg::SRC_OFS;
	wire wrFpsr    = wrPend && wrAddr == fmd_pkg::FPSR_OFS;
	wire wrFpr     = wrPend && fprWr;
	wire idle      = state == fmd_pkg::ST_IDLE;
	wire finish    = state == fmd_pkg::ST_FINISH;
	wire [31:0] statWord = {16'h0, lastCmd.rm, lastCmd.spec, eaKindL, 2'b00,
		noExec, fmtBadL, eaBadL, idMiss, done, !idle};

	// Read selection by address
	always_comb begin
		if (rdAddr == fmd_pkg::CMD_OFS) rdMux = lastCmd;
		else if (rdAddr == fmd_pkg::SRC_OFS) rdMux = srcData;
		else if (rdAddr == fmd_pkg::STAT_OFS) rdMux = statWord;
		else if (rdAddr == fmd_pkg::FPSR_OFS) rdMux = {8'h00, qByte, exc, acc};
		else if (rdAddr == fmd_pkg::EXPO_OFS) rdMux = {{20{lastExp[11]}}, lastExp};
		else if (fprRd) rdMux = toIeee(fpr[rdAddr[4:2]]);
		else rdMux = 32'h0;
	end

	// Address capture, one wait state on reads
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			wrPend    <= 1'b0;
			rdPend    <= 1'b0;
			wrAddr    <= 8'h00;
			rdAddr    <= 8'h00;
			hreadyout <= 1'b1;
			hresp     <= 1'b0;
			hrdata    <= 32'h0;
		end else if (ce) begin
			wrPend    <= addrPhase & hwrite;
			rdPend    <= addrPhase & ~hwrite;
			hreadyout <= ~(addrPhase & ~hwrite);
			if (addrPhase) wrAddr <= haddr[7:0];
			if (addrPhase) rdAddr <= haddr[7:0];
			if (rdPend) hrdata <= rdMux;
		end
	end

	// ************************************************
	// Command decode
	// ************************************************
	wire fmd_pkg::cmd_t    cw     = fmd_pkg::cmd_t'(hwdata);
	wire fmd_pkg::ea_kind_t eaK   = eaKindOf(cw.mode, cw.eaReg);
	wire fmd_pkg::fmt_t    fmt    = fmd_pkg::fmt_t'(cw.spec);
	wire idHit  = cw.trig == fmd_pkg::TRIG_CODE && cw.cpid == OWN_ID;
	wire isMul  = cw.opm == fmd_pkg::OPM_MUL;
	wire isSin  = cw.opm == fmd_pkg::OPM_SIN;
	wire isDiv  = cw.opm == fmd_pkg::OPM_DIV;
	wire eaBad  = cw.rm && (eaK == fmd_pkg::EA_AREG || eaK == fmd_pkg::EA_BAD);
	wire fmtOk  = fmt == fmd_pkg::F_LONG || fmt == fmd_pkg::F_SNG ||
		fmt == fmd_pkg::F_WORD || fmt == fmd_pkg::F_BYTE;
	wire fmtBad = cw.rm && !fmtOk;
	wire runIt  = wrCmd && idle && idHit && (isMul || isSin) && !eaBad && !fmtBad;

	// Source operand: register, or memory data converted by format
	wire [31:0] intVal = (fmt == fmd_pkg::F_WORD) ? {{16{srcData[15]}}, srcData[15:0]} :
		(fmt == fmd_pkg::F_BYTE) ? {{24{srcData[7]}}, srcData[7:0]} : srcData;
	wire [31:0] intMag = intVal[31] ? 32'(-intVal) : intVal;
	wire fmd_pkg::fp_val_t memVal = (fmt == fmd_pkg::F_SNG) ? fromIeee(srcData) :
		mkVal(intVal[31], {12'h000, intMag}, 12'sh000);
	wire fmd_pkg::fp_val_t srcVal = cw.rm ? memVal : fpr[cw.spec];

	// Fixed-point argument, 20 fraction bits, huge exponents capped
	wire signed [11:0] fe = (srcVal.exp > fmd_pkg::BIG_EXP) ? fmd_pkg::BIG_EXP : srcVal.exp;
	wire [43:0] mant44 = {20'h0, srcVal.mant};
	wire [43:0] fixMag = (fe >= 12'sh003) ? (mant44 << (fe - 12'sh003)) :
		(mant44 >> (12'sh003 - fe));
	wire sinLong = isSin && srcVal.cls == fmd_pkg::CL_NUM && srcVal.exp >= fmd_pkg::SMALL_EXP;

	// ************************************************
	// Sine engine datapath
	// ************************************************
	wire [43:0] redStep = fmd_pkg::TWO_PI << kCnt;
	wire [43:0] rNext   = (rAcc >= redStep) ? rAcc - redStep : rAcc;
	wire        pastPi  = rNext >= fmd_pkg::PI;
	wire [43:0] r1      = pastPi ? rNext - fmd_pkg::PI : rNext;
	wire [43:0] r2      = (r1 > fmd_pkg::HALF_PI) ? fmd_pkg::PI - r1 : r1;
	wire        zNeg    = cz[23];
	wire signed [23:0] yShift = cy >>> it;
	wire signed [23:0] xShift = cx >>> it;
	wire signed [23:0] angle  = fmd_pkg::atanTab(it);
	wire        yNeg    = cy[23];
	wire [23:0] yAbs    = yNeg ? 24'(-cy) : cy;
	wire fmd_pkg::fp_val_t sinVal = mkVal(flip ^ yNeg, {20'h0, yAbs}, fmd_pkg::FIX_SCALE);

	// ************************************************
	// Result and exception evaluation
	// ************************************************
	logic [47:0] prod;
	logic [23:0] m0;
	logic [24:0] mr;
	logic        hi, grd, stk, operand_error_flag, result_inexact_flag;
	always_comb begin
		prod   = srcLat.mant * dstLat.mant;
		hi     = prod[47];
		m0     = hi ? prod[47:24] : prod[46:23];
		grd    = hi ? prod[23] : prod[22];
		stk    = hi ? |prod[22:0] : |prod[21:0];
		mr     = {1'b0, m0} + {24'h0, grd & (stk | m0[0])};
		operand_error_flag  = 1'b0;
		result_inexact_flag  = 1'b0;
		resVal = srcLat;
		resVal.sign = srcLat.sign ^ dstLat.sign;
		if (opIsSin) begin
			resVal = srcLat;
			if (srcLat.cls == fmd_pkg::CL_INF) begin
				resVal.cls = fmd_pkg::CL_NAN;
				operand_error_flag      = 1'b1;
			end else if (srcLat.cls == fmd_pkg::CL_NUM) begin
				result_inexact_flag = 1'b1;
				if (srcLat.exp >= fmd_pkg::SMALL_EXP) resVal = sinVal;
			end
		end else if (srcLat.cls == fmd_pkg::CL_NAN || dstLat.cls == fmd_pkg::CL_NAN) begin
			resVal.cls = fmd_pkg::CL_NAN;
		end else if ((srcLat.cls == fmd_pkg::CL_ZERO && dstLat.cls == fmd_pkg::CL_INF) ||
			(srcLat.cls == fmd_pkg::CL_INF && dstLat.cls == fmd_pkg::CL_ZERO)) begin
			resVal.cls = fmd_pkg::CL_NAN;
			operand_error_flag      = 1'b1;
		end else if (srcLat.cls == fmd_pkg::CL_INF || dstLat.cls == fmd_pkg::CL_INF) begin
			resVal.cls = fmd_pkg::CL_INF;
		end else if (srcLat.cls == fmd_pkg::CL_ZERO || dstLat.cls == fmd_pkg::CL_ZERO) begin
			resVal.cls = fmd_pkg::CL_ZERO;
		end else begin
			resVal.cls  = fmd_pkg::CL_NUM;
			resVal.mant = mr[24] ? mr[24:1] : mr[23:0];
			resVal.exp  = srcLat.exp + dstLat.exp + $signed({11'h000, hi}) +
				$signed({11'h000, mr[24]});
			result_inexact_flag       = grd | stk;
		end
		newExc            = 8'h00;
		newExc[fmd_pkg::EX_OPERAND_ERROR_FLAG] = operand_error_flag;
		newExc[fmd_pkg::EX_RESULT_INEXACT_FLAG] = result_inexact_flag;
		accSet            = 8'h00;
		accSet[fmd_pkg::AE_IOP]  = newExc[fmd_pkg::EX_BRANCH_UNORDERED_FLAG] | newExc[fmd_pkg::EX_SIGNALLING_NAN_FLAG] |
			newExc[fmd_pkg::EX_OPERAND_ERROR_FLAG];
		accSet[fmd_pkg::AE_OVERFLOW_FLAG] = newExc[fmd_pkg::EX_OVERFLOW_FLAG];
		accSet[fmd_pkg::AE_UNDERFLOW_FLAG] = newExc[fmd_pkg::EX_UNDERFLOW_FLAG] & newExc[fmd_pkg::EX_RESULT_INEXACT_FLAG];
		accSet[fmd_pkg::AE_DZ]   = newExc[fmd_pkg::EX_DZ];
		accSet[fmd_pkg::AE_INEX] = newExc[fmd_pkg::EX_INPUT_INEXACT_FLAG] | newExc[fmd_pkg::EX_RESULT_INEXACT_FLAG] |
			newExc[fmd_pkg::EX_OVERFLOW_FLAG];
	end

	// ************************************************
	// Sequencer
	// ************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			state   <= fmd_pkg::ST_IDLE;
			srcLat  <= fmd_pkg::ZERO_VAL;
			dstLat  <= fmd_pkg::ZERO_VAL;
			opIsSin <= 1'b0;
			dstIdx  <= 3'h0;
			flip    <= 1'b0;
			rAcc    <= 44'h0;
			kCnt    <= 5'h00;
			it      <= 4'h0;
			cx      <= 24'sh000000;
			cy      <= 24'sh000000;
			cz      <= 24'sh000000;
		end else if (ce) begin
			case (state)
				fmd_pkg::ST_IDLE: begin
					if (runIt) begin
						srcLat  <= srcVal;
						dstLat  <= fpr[cw.dst];
						dstIdx  <= cw.dst;
						opIsSin <= isSin;
						flip    <= srcVal.sign;
						rAcc    <= fixMag;
						kCnt    <= fmd_pkg::RED_TOP;
						state   <= sinLong ? fmd_pkg::ST_REDUCE : fmd_pkg::ST_FINISH;
					end
				end
				fmd_pkg::ST_REDUCE: begin
					rAcc <= rNext;
					kCnt <= kCnt - 5'h01;
					if (kCnt == 5'h00) begin
						cz    <= $signed(r2[23:0]);
						cx    <= fmd_pkg::CORDIC_K;
						cy    <= 24'sh000000;
						it    <= 4'h0;
						flip  <= flip ^ pastPi;
						state <= fmd_pkg::ST_ROTATE;
					end
				end
				fmd_pkg::ST_ROTATE: begin
					cx <= zNeg ? cx + yShift : cx - yShift;
					cy <= zNeg ? cy - xShift : cy + xShift;
					cz <= zNeg ? cz + angle : cz - angle;
					it <= it + 4'h1;
					if (it == fmd_pkg::ROT_LAST) state <= fmd_pkg::ST_FINISH;
				end
				default: state <= fmd_pkg::ST_IDLE;
			endcase
		end
	end

	// ************************************************
	// Software-visible registers
	// ************************************************
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			srcData <= fmd_pkg::SRC_RST;
			lastCmd <= fmd_pkg::cmd_t'(32'h0);
			eaKindL <= fmd_pkg::EA_DREG;
			{done, idMiss, eaBadL, fmtBadL, noExec} <= 5'h00;
			qByte   <= fmd_pkg::BYTE_RST;
			exc     <= fmd_pkg::BYTE_RST;
			acc     <= fmd_pkg::BYTE_RST;
			lastExp <= 12'sh000;
		end else if (ce) begin
			if (wrSrc) srcData <= hwdata;
			if (wrCmd && idle) begin
				lastCmd <= cw;
				eaKindL <= eaK;
				done    <= 1'b0;
				idMiss  <= !idHit;
				eaBadL  <= eaBad;
				fmtBadL <= fmtBad;
				noExec  <= !(isMul || isSin) || isDiv;
			end
			// Completion wins over a software write
			if (finish) begin
				exc     <= newExc;
				acc     <= acc | accSet;
				lastExp <= resVal.exp;
				done    <= 1'b1;
			end else if (wrFpsr) begin
				{exc, acc} <= hwdata[15:0];
			end
			if (wrFpsr) qByte <= hwdata[23:16];
		end
	end

	// Data register file, results beat bus writes
	for (genvar g = 0; g < 8; g++) begin : gFpr
		always_ff @(posedge clk) begin
			if (!rst_n) begin
				fpr[g] <= fmd_pkg::ZERO_VAL;
			end else if (ce) begin
				if (finish && dstIdx == 3'(g)) fpr[g] <= resVal;
				else if (wrFpr && wrAddr[4:2] == 3'(g)) fpr[g] <= fromIeee(hwdata);
			end
		end
	end
endmodule : fp_mulsin_dec

/* File: fmd_pkg.sv */
/*
 * Shared constants and types of the coprocessor multiply and sine decoder:
 * register map, instruction word layout, status bit positions, internal
 * number format and the fixed-point constants of the sine engine.
 * Assumes a 32-bit register bus and a 25 MHz single clock.
 */
package fmd_pkg;
	// ************************************************
	// Register byte offsets
	// ************************************************
	localparam logic [7:0] CMD_OFS  = 8'h00;
	localparam logic [7:0] SRC_OFS  = 8'h04;
	localparam logic [7:0] STAT_OFS = 8'h08;
	localparam logic [7:0] FPSR_OFS = 8'h0c;
	localparam logic [7:0] EXPO_OFS = 8'h10;
	localparam logic [7:0] FPR_OFS  = 8'h20;
	localparam logic [31:0] SRC_RST  = 32'h0000_0000;
	localparam logic [7:0]  BYTE_RST = 8'h00;

	// ************************************************
	// Instruction word fields and codes
	// ************************************************
	localparam logic [3:0] TRIG_CODE = 4'hf;
	localparam logic [2:0] FPU_ID    = 3'h1;
	localparam logic [6:0] OPM_DIV   = 7'h24;
	localparam logic [6:0] OPM_MUL   = 7'h27;
	localparam logic [6:0] OPM_SIN   = 7'h0e;
	typedef struct packed {
		logic [3:0] trig;
		logic [2:0] cpid;
		logic [2:0] zeroA;
		logic [2:0] mode;
		logic [2:0] eaReg;
		logic       zeroB;
		logic       rm;
		logic       zeroC;
		logic [2:0] spec;
		logic [2:0] dst;
		logic [6:0] opm;
	} cmd_t;
	typedef enum logic [2:0] {
		F_LONG = 3'h0, F_SNG = 3'h1, F_EXT = 3'h2, F_PACK = 3'h3,
		F_WORD = 3'h4, F_DBL = 3'h5, F_BYTE = 3'h6, F_NONE = 3'h7
	} fmt_t;
	typedef enum logic [3:0] {
		EA_DREG, EA_AREG, EA_IND, EA_POSTINC, EA_PREDEC, EA_DISP,
		EA_INDEX, EA_ABSW, EA_ABSL, EA_IMM, EA_PCREL, EA_BAD
	} ea_kind_t;

	// ************************************************
	// Exception and accrued byte bit positions
	// ************************************************
	localparam int EX_BRANCH_UNORDERED_FLAG = 7, EX_SIGNALLING_NAN_FLAG = 6, EX_OPERAND_ERROR_FLAG = 5, EX_OVERFLOW_FLAG = 4;
	localparam int EX_UNDERFLOW_FLAG = 3, EX_DZ = 2, EX_RESULT_INEXACT_FLAG = 1, EX_INPUT_INEXACT_FLAG = 0;
	localparam int AE_IOP = 7, AE_OVERFLOW_FLAG = 6, AE_UNDERFLOW_FLAG = 5, AE_DZ = 4, AE_INEX = 3;

	// ************************************************
	// Internal number format and sine engine
	// ************************************************
	typedef enum logic [1:0] {CL_NUM, CL_ZERO, CL_INF, CL_NAN} cls_t;
	typedef struct packed {
		logic              sign;
		cls_t              cls;
		logic signed [11:0] exp;
		logic [23:0]       mant;
	} fp_val_t;
	localparam fp_val_t ZERO_VAL = '{1'b0, CL_ZERO, 12'sh000, 24'h000000};
	localparam logic signed [11:0] SGL_BIAS  = 12'sh07f;
	localparam logic signed [11:0] SMALL_EXP = -12'sh00c;
	localparam logic signed [11:0] BIG_EXP   = 12'sh016;
	localparam logic signed [11:0] FIX_SCALE = 12'sh014;
	localparam logic [43:0] TWO_PI  = 44'h000_0064_87ed;
	localparam logic [43:0] PI      = 44'h000_0032_43f7;
	localparam logic [43:0] HALF_PI = 44'h000_0019_21fb;
	localparam logic [4:0]  RED_TOP = 5'h15;
	localparam logic [3:0]  ROT_LAST = 4'hf;
	localparam logic signed [23:0] CORDIC_K = 24'sh09b74f;
	typedef enum logic [1:0] {
		ST_IDLE = 2'b00, ST_REDUCE = 2'b01, ST_ROTATE = 2'b11, ST_FINISH = 2'b10
	} state_t;

	// Rotation angle per step, 20 fraction bits
	function automatic logic signed [23:0] atanTab(input logic [3:0] i);
		case (i)
			4'h0:    atanTab = 24'sh0c90fe;
			4'h1:    atanTab = 24'sh076b1a;
			4'h2:    atanTab = 24'sh03eb6f;
			4'h3:    atanTab = 24'sh01fd5c;
			4'h4:    atanTab = 24'sh00ffab;
			4'h5:    atanTab = 24'sh007ff5;
			4'h6:    atanTab = 24'sh003fff;
			default: atanTab = 24'sh100000 >>> i;
		endcase
	endfunction : atanTab
endpackage : fmd_pkg

/* File: fmd_checker.sv */
/*
 * Bus timing checks of the multiply and sine decoder, bound to its top.
 * Assumes one slave, so hready is the design's own hreadyout.
 */
`timescale 1ns/10ps
module fmd_checker (
	// Clock and control
	input wire logic        clk,
	input wire logic        rst_n,
	input wire logic        ce,
	// AHB-Lite slave side
	input wire logic        hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0]  htrans,
	input wire logic        hwrite,
	input wire logic [2:0]  hsize,
	input wire logic        hready,
	input wire logic [31:0] hwdata,
	input wire logic        hreadyout,
	input wire logic        hresp,
	input wire logic [31:0] hrdata
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_n || !ce);
	// Accepted address phases and unmapped holes
	wire logic acc   = hsel && htrans[1] && hready;
	wire logic rdAcc = acc && !hwrite;
	wire logic hole  = (haddr[7:0] inside {8'h14, 8'h18, 8'h1c}) || (haddr[7:6] != 2'b00);
	sequence s_waitData;
		!hreadyout ##1 hreadyout;
	endsequence
	property p_okay; hresp == 1'b0; endproperty
	property p_rstOut; $past(rst_n) == 1'b0 |-> hreadyout && hrdata == 32'h0; endproperty
	property p_wrZero; acc && hwrite |=> hreadyout; endproperty
	property p_rdWait; rdAcc |=> s_waitData; endproperty
	property p_hole; rdAcc && hole |=> ##1 hrdata == 32'h0; endproperty
	property p_lowOne; !hreadyout |=> hreadyout; endproperty
	property p_lowCause; !hreadyout |-> $past(rdAcc); endproperty
	property p_stayHigh; hreadyout && !rdAcc |=> hreadyout; endproperty
	a_okay:     assert property (p_okay) else $error("hresp not okay");
	a_rstOut:   assert property (p_rstOut) else $error("bus outputs not reset");
	a_wrZero:   assert property (p_wrZero) else $error("write data phase waited");
	a_rdWait:   assert property (p_rdWait) else $error("read wait not one cycle");
	a_hole:     assert property (p_hole) else $error("hole read not zero");
	a_lowOne:   assert property (p_lowOne) else $error("ready low too long");
	a_lowCause: assert property (p_lowCause) else $error("ready low without read");
	a_stayHigh: assert property (p_stayHigh) else $error("ready dropped unasked");
endmodule : fmd_checker

bind fp_mulsin_dec fmd_checker i_fmd_checker (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel),
	.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hready),
	.hwdata(hwdata), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));

/* File: fmd_host.sv */
/*
 * Host processor model: AHB-Lite single word master and command builder.
 * Assumes callers enter its tasks just after a rising clock edge.
 */
`timescale 1ns/10ps
module fmd_host (
	// Clock and answer
	input wire logic        clk,
	input wire logic        hreadyIn,
	input wire logic [31:0] hrdata,
	// Request
	output logic            hsel,
	output logic [31:0]     haddr,
	output logic [1:0]      htrans,
	output logic            hwrite,
	output logic [2:0]      hsize,
	output logic [31:0]     hwdata
);
	initial begin
		hsel = 1'b1; haddr = 32'h0; htrans = 2'b00; hwrite = 1'b0; hsize = 3'h2; hwdata = 32'h0;
	end
	// Unused ea field left zero on register to register forms
	function automatic logic [31:0] mkCmd(input logic [2:0] id, input logic rm,
		input logic [2:0] md, rg, sp, ds, input logic [6:0] op);
		mkCmd = {fmd_pkg::TRIG_CODE, id, 3'h0, rm ? md : 3'h0, rm ? rg : 3'h0, 1'b0, rm, 1'b0,
			sp, ds, op};
	endfunction : mkCmd
	// One transfer: address phase, then data phase
	task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		haddr  <= {24'h0, a};
		hwrite <= wr;
		htrans <= 2'b10;
		@(posedge clk);
		while (!hreadyIn) @(posedge clk);
		htrans <= 2'b00;
		hwdata <= d;
		@(posedge clk);
		while (!hreadyIn) @(posedge clk);
		q = hrdata;
	endtask : xfer
endmodule : fmd_host

/* File: fp_single_mul_sine_decode_tb_top.sv */
/*
 * Self-checking bench of the multiply and sine decoder.
 * Assumes the host model drives the bus and the checker is bound.
 */
`timescale 1ns/10ps
module fp_single_mul_sine_decode_tb_top;
	logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, hsel, hwrite, hreadyout, hresp;
	logic [31:0] haddr, hwdata, hrdata, q;
	logic [1:0]  htrans;
	logic [2:0]  hsize;
	int          errorCnt = 0, nCompared = 0;
	localparam logic [2:0] ID = fmd_pkg::FPU_ID;
	always #20 clk = ~clk;
	fp_mulsin_dec i_fp_mulsin_dec (.clk(clk), .rst_n(rst_n), .ce(ce), .hsel(hsel), .haddr(haddr),
		.htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hready(hreadyout), .hwdata(hwdata),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata));
	fmd_host i_fmd_host (.clk(clk), .hreadyIn(hreadyout), .hrdata(hrdata), .hsel(hsel),
		.haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata));
	// ****************************************
	// Shared bus and compare tasks
	// ****************************************
	function automatic logic [7:0] fp(input int n);
		fp = fmd_pkg::FPR_OFS + 8'(4 * n);
	endfunction : fp
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		i_fmd_host.xfer(1'b1, a, d, q);
	endtask : wr
	task automatic rdChk(input string nm, input logic [7:0] a, input logic [31:0] m, e);
		i_fmd_host.xfer(1'b0, a, 32'h0, q);
		nCompared++;
		if ((q & m) !== e) begin
			errorCnt++;
			$display("unexpected %s exp %h got %h", nm, e, q & m);
		end
	endtask : rdChk
	task automatic run(input logic [2:0] id, input logic rm, input logic [2:0] md, rg, sp, ds,
		input logic [6:0] op);
		int n;
		wr(fmd_pkg::CMD_OFS, i_fmd_host.mkCmd(id, rm, md, rg, sp, ds, op));
		q = 32'h1;
		for (n = 0; n < 200 && q[0] !== 1'b0; n++) i_fmd_host.xfer(1'b0, fmd_pkg::STAT_OFS, 0, q);
		if (n == 200) begin
			errorCnt++;
			$display("unexpected busy exp 0 got 1");
		end
	endtask : run
	task automatic t_reset;
		rdChk("fpsr", fmd_pkg::FPSR_OFS, '1, 32'h0);
		rdChk("src", fmd_pkg::SRC_OFS, '1, fmd_pkg::SRC_RST);
		rdChk("fp0", fp(0), '1, 32'h0);
		wr(8'h14, 32'hdead_beef);
		rdChk("hole", 8'h14, '1, 32'h0);
	endtask : t_reset
	task automatic t_mul;
		wr(fp(1), 32'h4040_0000);
		wr(fmd_pkg::SRC_OFS, 32'h5);
		wr(fmd_pkg::FPSR_OFS, 32'h00ab_8400);
		run(ID, 1'b1, 3'h0, 3'h0, 3'h0, 3'h1, fmd_pkg::OPM_MUL);
		rdChk("fp1", fp(1), '1, 32'h4170_0000);
		rdChk("stat", fmd_pkg::STAT_OFS, 32'hffff, 32'h8002);
		rdChk("fpsr", fmd_pkg::FPSR_OFS, '1, 32'h00ab_0000);
		wr(fp(5), 32'h4040_0000);
		wr(fmd_pkg::SRC_OFS, 32'h1234_fffe);
		run(ID, 1'b1, 3'h2, 3'h0, 3'h4, 3'h5, fmd_pkg::OPM_MUL);
		rdChk("fp5", fp(5), '1, 32'hc0c0_0000);
		wr(fp(0), 32'h7180_0000);
		run(ID, 1'b0, 3'h0, 3'h0, 3'h0, 3'h0, fmd_pkg::OPM_MUL);
		rdChk("expo", fmd_pkg::EXPO_OFS, '1, 32'h0000_00c8);
		rdChk("fp0", fp(0), '1, 32'h7f80_0000);
		wr(fp(3), 32'h3f80_0001);
		run(ID, 1'b0, 3'h0, 3'h0, 3'h3, 3'h3, fmd_pkg::OPM_MUL);
		rdChk("fp3", fp(3), '1, 32'h3f80_0002);
		rdChk("fpsr", fmd_pkg::FPSR_OFS, '1, 32'h00ab_0208);
	endtask : t_mul
	task automatic t_special;
		wr(fp(2), 32'h7f80_0000);
		wr(fp(3), 32'h8000_0000);
		wr(fp(6), 32'hff80_0000);
		run(ID, 1'b0, 3'h0, 3'h0, 3'h3, 3'h2, fmd_pkg::OPM_MUL);
		rdChk("fp2", fp(2), 32'h7fff_ffff, 32'h7fc0_0000);
		rdChk("fpsr", fmd_pkg::FPSR_OFS, '1, 32'h00ab_2088);
		run(ID, 1'b0, 3'h0, 3'h0, 3'h1, 3'h3, fmd_pkg::OPM_MUL);
		rdChk("fp3", fp(3), '1, 32'h8000_0000);
		run(ID, 1'b0, 3'h0, 3'h0, 3'h1, 3'h6, fmd_pkg::OPM_MUL);
		rdChk("fp6", fp(6), '1, 32'hff80_0000);
		rdChk("fpsr", fmd_pkg::FPSR_OFS, '1, 32'h00ab_0088);
	endtask : t_special
	task automatic t_sine;
		wr(fmd_pkg::FPSR_OFS, 32'h00ab_9400);
		wr(fmd_pkg::SRC_OFS, 32'h4170_0000);
		wr(fmd_pkg::CMD_OFS, i_fmd_host.mkCmd(ID, 1'b1, 3'h0, 3'h0, 3'h1, 3'h4, fmd_pkg::OPM_SIN));
		ce <= 1'b0;
		repeat (5) @(posedge clk);
		ce <= 1'b1;
		run(ID, 1'b0, 3'h0, 3'h0, 3'h1, 3'h1, 7'h7f);
		i_fmd_host.xfer(1'b0, fp(4), 32'h0, q);
		nCompared++;
		if ($isunknown(q) || q < 32'h3f26_7140 || q > 32'h3f26_8140) begin
			errorCnt++;
			$display("unexpected fp4 exp 3f267940 got %h", q);
		end
		rdChk("stat", fmd_pkg::STAT_OFS, 32'h3f, 32'h02);
		rdChk("fpsr", fmd_pkg::FPSR_OFS, '1, 32'h00ab_0208);
		run(ID, 1'b0, 3'h0, 3'h0, 3'h3, 3'h5, fmd_pkg::OPM_SIN);
		rdChk("fp5", fp(5), '1, 32'h8000_0000);
		run(ID, 1'b0, 3'h0, 3'h0, 3'h6, 3'h6, fmd_pkg::OPM_SIN);
		rdChk("fp6", fp(6), 32'h7fff_ffff, 32'h7fc0_0000);
		rdChk("fpsr", fmd_pkg::FPSR_OFS, '1, 32'h00ab_2088);
	endtask : t_sine
	task automatic refuse(input logic [2:0] id, input logic rm, input logic [2:0] md, rg, sp,
		input logic [6:0] op, input logic [31:0] flag);
		run(id, rm, md, rg, sp, 3'h7, op);
		rdChk("stat", fmd_pkg::STAT_OFS, 32'h3f, flag);
		rdChk("fp7", fp(7), '1, 32'h3f80_0000);
	endtask : refuse
	task automatic t_refuse;
		wr(fp(7), 32'h3f80_0000);
		refuse(3'h2, 1'b0, 3'h0, 3'h0, 3'h0, fmd_pkg::OPM_MUL, 32'h04);
		refuse(ID, 1'b0, 3'h0, 3'h0, 3'h0, fmd_pkg::OPM_DIV, 32'h20);
		refuse(ID, 1'b1, 3'h0, 3'h0, 3'h2, fmd_pkg::OPM_MUL, 32'h10);
		refuse(ID, 1'b1, 3'h1, 3'h0, 3'h0, fmd_pkg::OPM_MUL, 32'h08);
		refuse(ID, 1'b1, 3'h7, 3'h5, 3'h0, fmd_pkg::OPM_MUL, 32'h08);
		rdChk("fpsr", fmd_pkg::FPSR_OFS, '1, 32'h00ab_2088);
	endtask : t_refuse
	task automatic t_decode;
		logic [2:0] md [11] = '{0, 2, 3, 4, 5, 6, 7, 7, 7, 7, 7};
		logic [2:0] rg [11] = '{0, 0, 0, 0, 0, 0, 0, 1, 4, 2, 3};
		logic [3:0] kd [11] = '{0, 2, 3, 4, 5, 6, 7, 8, 9, 10, 10};
		for (int i = 0; i < 11; i++) begin
			run(ID, 1'b1, md[i], rg[i], 3'h0, 3'h7, fmd_pkg::OPM_MUL);
			rdChk("kind", fmd_pkg::STAT_OFS, 32'h0f00, {20'h0, kd[i], 8'h0});
		end
		for (int s = 0; s < 7; s++) begin
			run(ID, 1'b1, 3'h0, 3'h0, 3'(s), 3'h7, fmd_pkg::OPM_MUL);
			rdChk("fmt", fmd_pkg::STAT_OFS, 32'h7010,
				{17'h0, 3'(s), 7'h0, s == 2 || s == 3 || s == 5, 4'h0});
		end
	endtask : t_decode
	task automatic finishTest;
		if (errorCnt == 0 && nCompared > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : finishTest
	// Main sequence and watchdog
	initial begin
		repeat (20) @(posedge clk);
		rst_n <= 1'b1;
		repeat (2) @(posedge clk);
		t_reset;
		t_mul;
		t_special;
		t_sine;
		t_refuse;
		t_decode;
		finishTest;
	end
	initial begin
		#1ms;
		errorCnt++;
		finishTest;
	end
endmodule : fp_single_mul_sine_decode_tb_top
